/* pkg/bdpe_consts.svh */
// Constants of the balanced dual pixel control encoder: patterns, lanes, limits.
`ifndef BDPE_CONSTS_SVH
`define BDPE_CONSTS_SVH

// ==========================================================================
// Control patterns, leftmost bit in bit 6, balance bit in bit 0
// ==========================================================================
// Valid-flag state on the clock lanes; POS has positive disparity.
`define BDPE_DE_HI_POS      7'h78
`define BDPE_DE_HI_NEG      7'h70
`define BDPE_DE_LO_POS      7'h7c
`define BDPE_DE_LO_NEG      7'h60
// Sync and auxiliary control lines.
`define BDPE_CT_HI_POS      7'h7c
`define BDPE_CT_HI_NEG      7'h60
`define BDPE_CT_LO_POS      7'h78
`define BDPE_CT_LO_NEG      7'h70
// Fixed word on inactive lanes and on lanes with nothing to carry.
`define BDPE_IDLE_WORD      7'h00

// ==========================================================================
// Lane assignment
// ==========================================================================
`define BDPE_LANE_HSYNC     3'h0
`define BDPE_LANE_VSYNC     3'h1
`define BDPE_LANE_IDLE_A    3'h3
`define BDPE_LANE_AUX_F     3'h4
`define BDPE_LANE_AUX_E     3'h5
`define BDPE_LANE_IDLE_B    3'h7

// ==========================================================================
// Running disparity limits and reset values
// ==========================================================================
`define BDPE_DISP_MAX       6'sh0a
`define BDPE_DISP_MIN       (-6'sh09)
`define BDPE_DISP_RESET     5'h00
`define BDPE_CFG_RESET      2'h1

`endif

/* pkg/bdpe_pkg.sv */
// Types shared by the balanced dual pixel control encoder.
package bdpe_pkg;

    // ======================================================================
    // Carriers
    // ======================================================================
    typedef logic [6:0] bdpe_word_t;

    typedef struct packed {
        logic pixel_valid_flag;
        logic hsync;
        logic vsync;
        logic aux_control_e;
        logic aux_control_f;
    } bdpe_ctrl_s;

    typedef struct packed {
        logic dual24;              // 1: 24-bit dual mode, 0: 18-bit dual mode.
        logic valid_active_high;   // Level of the valid flag during pixel data.
    } bdpe_cfg_s;

    // ======================================================================
    // State of each clock domain
    // ======================================================================
    typedef struct packed {
        bdpe_cfg_s cfg;
    } bdpe_sys_s;

    typedef struct packed {
        logic                  rst_s1;
        logic                  rst_s2;
        logic                  run;
        bdpe_cfg_s             cfg_s1;
        bdpe_cfg_s             cfg_s2;
        bdpe_word_t [7:0]      lane;
        bdpe_word_t            clk_word;
        logic       [7:0][4:0] disp;
        logic       [4:0]      clk_disp;
    } bdpe_link_s;

endpackage

/* hw/bdpe_encoder.sv */
// Balanced dual pixel encoder: control words in blanking, lane words per pixel clock.
`timescale 1ns/1ps
`include "bdpe_consts.svh"

module bdpe_encoder (
    input  wire logic                      sys_clk,              // System clock, 200 MHz.
    input  wire logic                      rst_b,                // Sync reset, active low.
    input  wire bdpe_pkg::bdpe_cfg_s       cfg,                  // Mode and polarity.
    input  wire logic                      link_clk,             // Pixel clock of the link.
    input  wire bdpe_pkg::bdpe_ctrl_s      ctrl,                 // Controls, link domain.
    input  wire bdpe_pkg::bdpe_word_t [7:0] pixel_word,          // Encoded pixel words.
    output bdpe_pkg::bdpe_word_t [7:0]     data_lane,            // Words to serializer.
    output bdpe_pkg::bdpe_word_t           primary_clock_lane,   // First clock lane word.
    output bdpe_pkg::bdpe_word_t           secondary_clock_lane  // Second clock lane word.
);
    import bdpe_pkg::*;

    // ======================================================================
    // Helpers
    // ======================================================================
    // Ones minus zeros of a seven-bit word, balance bit included.
    function automatic logic signed [4:0] word_disp(input bdpe_word_t w);
        logic signed [4:0] d;
        d = -5'sh07;
        for (int i = 0; i < 7; i++) begin
            d = d + (w[i] ? 5'sh02 : 5'sh00);
        end
        return d;
    endfunction

    // A positive running disparity takes the negative pattern, else the positive one.
    function automatic bdpe_word_t pick(input logic [4:0] rd, input bdpe_word_t pos,
                                        input bdpe_word_t neg);
        return ($signed(rd) > 5'sh00) ? neg : pos;
    endfunction

    // Saturating accumulation of one word's disparity.
    function automatic logic [4:0] accum(input logic [4:0] rd, input bdpe_word_t w);
        logic signed [4:0] wd;
        logic signed [5:0] s;
        wd = word_disp(w);
        s = $signed({rd[4], rd}) + $signed({wd[4], wd});
        if (s > `BDPE_DISP_MAX) begin
            s = `BDPE_DISP_MAX;
        end else if (s < `BDPE_DISP_MIN) begin
            s = `BDPE_DISP_MIN;
        end
        return s[4:0];
    endfunction

    // ======================================================================
    // System domain: configuration register
    // ======================================================================
    bdpe_sys_s  sy;
    bdpe_sys_s  next_sy;
    bdpe_link_s lk;
    bdpe_link_s next_lk;
    logic       blank;

    // Configuration is held here so that the link side sees a steady level.
    always_comb begin
        next_sy = sy;
        if (!rst_b) begin
            next_sy.cfg = `BDPE_CFG_RESET;
        end else begin
            next_sy.cfg = cfg;
        end
    end

    always_ff @(posedge sys_clk) begin
        sy <= next_sy;
    end

    // ======================================================================
    // Link domain: crossing, control encoding and disparity
    // ======================================================================
    // Blanking follows the flag against the configured valid level.
    assign blank = (ctrl.pixel_valid_flag != lk.cfg_s2.valid_active_high);

    // Reset and configuration are levels and cross through two flops each; a
    // mode change mid-frame can tear one word, which is accepted for size.
    always_comb begin
        logic [7:0]  lvl;
        logic [7:0]  map;
        bdpe_word_t  w;
        bdpe_word_t  ck;
        lvl     = 8'h00;
        map     = 8'h00;
        w       = `BDPE_IDLE_WORD;
        ck      = `BDPE_IDLE_WORD;
        next_lk = lk;
        next_lk.rst_s1 = rst_b;
        next_lk.rst_s2 = lk.rst_s1;
        next_lk.cfg_s1 = sy.cfg;
        next_lk.cfg_s2 = lk.cfg_s1;
        // An unknown synchroniser output at power-up falls into the reset branch.
        if (lk.rst_s2) begin
            next_lk.run = 1'b1;
            // The flag state rides the clock lanes at all times.
            if (ctrl.pixel_valid_flag) begin
                ck = pick(lk.clk_disp, `BDPE_DE_HI_POS, `BDPE_DE_HI_NEG);
            end else begin
                ck = pick(lk.clk_disp, `BDPE_DE_LO_POS, `BDPE_DE_LO_NEG);
            end
            next_lk.clk_word = ck;
            next_lk.clk_disp = accum(lk.clk_disp, ck);
            // Lane map of the control lines, shared by both modes.
            lvl[`BDPE_LANE_HSYNC] = ctrl.hsync;
            lvl[`BDPE_LANE_VSYNC] = ctrl.vsync;
            lvl[`BDPE_LANE_AUX_E] = ctrl.aux_control_e;
            lvl[`BDPE_LANE_AUX_F] = ctrl.aux_control_f;
            map[`BDPE_LANE_HSYNC] = 1'b1;
            map[`BDPE_LANE_VSYNC] = 1'b1;
            map[`BDPE_LANE_AUX_E] = 1'b1;
            map[`BDPE_LANE_AUX_F] = 1'b1;
            for (int i = 0; i < 8; i++) begin
                if (!lk.cfg_s2.dual24 && (i == int'(`BDPE_LANE_IDLE_A) ||
                                          i == int'(`BDPE_LANE_IDLE_B))) begin
                    w = `BDPE_IDLE_WORD;
                end else if (!blank) begin
                    w = pixel_word[i];
                end else if (map[i] && lvl[i]) begin
                    w = pick(lk.disp[i], `BDPE_CT_HI_POS, `BDPE_CT_HI_NEG);
                end else if (map[i]) begin
                    w = pick(lk.disp[i], `BDPE_CT_LO_POS, `BDPE_CT_LO_NEG);
                end else begin
                    w = `BDPE_IDLE_WORD;
                end
                next_lk.lane[i] = w;
                next_lk.disp[i] = accum(lk.disp[i], w);
            end
        end else begin
            next_lk.run      = 1'b0;
            next_lk.lane     = '0;
            next_lk.clk_word = `BDPE_IDLE_WORD;
            next_lk.disp     = '0;
            next_lk.clk_disp = `BDPE_DISP_RESET;
        end
    end

    always_ff @(posedge link_clk) begin
        lk <= next_lk;
    end

    // Bit 6 of each word leaves the serializer first.
    assign data_lane            = lk.lane;
    assign primary_clock_lane   = lk.clk_word;
    assign secondary_clock_lane = lk.clk_word;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge link_clk); endclocking
    // The reset pin covers the first link edges, before the run flag is known.
    default disable iff (!rst_b || !lk.run);

    property p_idle_lanes;
        lk.rst_s2 && !lk.cfg_s2.dual24 |=>
            data_lane[3] == `BDPE_IDLE_WORD && data_lane[7] == `BDPE_IDLE_WORD;
    endproperty
    a_idle_lanes: assert property (p_idle_lanes)
        else $error("inactive lane not fixed in 18-bit mode");

    property p_pixel_pass;
        lk.rst_s2 && !blank |=> data_lane[0] == $past(pixel_word[0]) &&
                                data_lane[5] == $past(pixel_word[5]);
    endproperty
    a_pixel_pass: assert property (p_pixel_pass)
        else $error("pixel word not passed while valid");

    property p_hsync_word;
        lk.rst_s2 && blank |=> $past(ctrl.hsync) ?
            data_lane[0] inside {`BDPE_CT_HI_POS, `BDPE_CT_HI_NEG} :
            data_lane[0] inside {`BDPE_CT_LO_POS, `BDPE_CT_LO_NEG};
    endproperty
    a_hsync_word: assert property (p_hsync_word)
        else $error("wrong horizontal sync word in blanking");

    property p_aux_e_word;
        lk.rst_s2 && blank && lk.cfg_s2.dual24 |=> $past(ctrl.aux_control_e) ?
            data_lane[5] inside {`BDPE_CT_HI_POS, `BDPE_CT_HI_NEG} :
            data_lane[5] inside {`BDPE_CT_LO_POS, `BDPE_CT_LO_NEG};
    endproperty
    a_aux_e_word: assert property (p_aux_e_word)
        else $error("wrong control E word in blanking");

    property p_flag_clock;
        lk.rst_s2 |=> $past(ctrl.pixel_valid_flag) ?
            primary_clock_lane inside {`BDPE_DE_HI_POS, `BDPE_DE_HI_NEG} :
            primary_clock_lane inside {`BDPE_DE_LO_POS, `BDPE_DE_LO_NEG};
    endproperty
    a_flag_clock: assert property (p_flag_clock)
        else $error("clock lane does not carry the flag state");

    property p_clock_pair;
        primary_clock_lane == secondary_clock_lane;
    endproperty
    a_clock_pair: assert property (p_clock_pair)
        else $error("clock lanes differ");

    property p_balance_zero;
        lk.rst_s2 && blank |=> data_lane[1][0] == 1'b0 && data_lane[4][0] == 1'b0 &&
                               primary_clock_lane[0] == 1'b0;
    endproperty
    a_balance_zero: assert property (p_balance_zero)
        else $error("balance bit set in a control word");

    property p_first_bit;
        lk.rst_s2 && blank |=> data_lane[1][6] == 1'b1 && data_lane[0][6] == 1'b1;
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("control word leading bit misplaced");

    property p_choice;
        lk.rst_s2 && blank |=> ($signed($past(lk.disp[0])) > 5'sh00) ==
                                (word_disp(data_lane[0]) < 5'sh00);
    endproperty
    a_choice: assert property (p_choice)
        else $error("control pattern does not oppose running disparity");

    property p_saturate;
        $signed(lk.disp[0]) <= 5'sh0a && $signed(lk.disp[0]) >= -5'sh09 &&
        $signed(lk.clk_disp) <= 5'sh0a && $signed(lk.clk_disp) >= -5'sh09;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("running disparity outside its limits");

    c_blank_to_active: cover property (blank ##1 !blank);
    c_disp_top: cover property ($signed(lk.disp[0]) == 5'sh0a);
    c_mode24_blank: cover property (lk.cfg_s2.dual24 && blank ##1 blank);

endmodule

/* tb/bdpe_rx_model.sv */
// Receiver model that rebuilds lane words in serial order and decodes the controls.
`timescale 1ns/1ps

module bdpe_rx_model (
    input  wire bdpe_pkg::bdpe_word_t [7:0] data_lane,  // Lane words from the encoder.
    input  wire bdpe_pkg::bdpe_word_t       clock_lane, // Primary clock lane word.
    output logic                            rx_flag,    // Decoded valid flag level.
    output logic [3:0]                      rx_ctrl,    // Decoded hsync, vsync, E, F.
    output logic                            rx_bad      // Some word outside the control set.
);
    import bdpe_pkg::*;

    // ======================================================================
    // Decoding
    // ======================================================================
    // Shift the bits in as they leave the wire, first bit ending at the top.
    function automatic bdpe_word_t deser(bdpe_word_t w);
        bdpe_word_t r;
        r = '0;
        for (int i = 6; i >= 0; i--) begin
            r = {r[5:0], w[i]};
        end
        return r;
    endfunction

    // Level of a control word; any other word, or a set balance bit, is bad.
    function automatic logic [1:0] level(bdpe_word_t w);
        case (deser(w))
            7'h60, 7'h7c: return 2'b01;
            7'h70, 7'h78: return 2'b00;
            default:      return 2'b10;
        endcase
    endfunction

    // The clock lanes pair their patterns the other way round to the sync lanes.
    always_comb begin
        logic [1:0] c;
        logic [1:0] h;
        logic [1:0] v;
        logic [1:0] e;
        logic [1:0] f;
        c = level(clock_lane);
        h = level(data_lane[0]);
        v = level(data_lane[1]);
        e = level(data_lane[5]);
        f = level(data_lane[4]);
        rx_flag = ~c[0];
        rx_ctrl = {h[0], v[0], e[0], f[0]};
        rx_bad = c[1] | h[1] | v[1] | e[1] | f[1];
    end
endmodule

/* tb/balanced_dual_pixel_ctrl_encoder_tb.sv */
// Self-checking bench of the balanced dual pixel control encoder.
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin miscompares++; $display("ERROR %0t: %s", $time, msg); end end

module balanced_dual_pixel_ctrl_encoder_tb;
    import bdpe_pkg::*;

    // ======================================================================
    // Stimulus and observed signals
    // ======================================================================
    logic             sys_clk = 1'b0;
    logic             link_clk = 1'b0;
    logic             rst_b = 1'b0;
    bdpe_cfg_s        cfg = 2'b01;
    bdpe_ctrl_s       ctrl = 5'b01010;
    bdpe_word_t [7:0] pixel_word = '0;
    bdpe_word_t [7:0] data_lane;
    bdpe_word_t       primary_clock_lane;
    bdpe_word_t       secondary_clock_lane;
    logic             rx_flag;
    logic [3:0]       rx_ctrl;
    logic             rx_bad;
    int               miscompares = 0;
    int               n_compared = 0;

    // The link clock starts off phase so no edge meets a system clock edge.
    always #2.5 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #7.5 link_clk = ~link_clk;
    end

    bdpe_encoder DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .link_clk(link_clk), .ctrl(ctrl),
        .pixel_word(pixel_word), .data_lane(data_lane),
        .primary_clock_lane(primary_clock_lane), .secondary_clock_lane(secondary_clock_lane)
    );

    bdpe_rx_model RX (
        .data_lane(data_lane), .clock_lane(primary_clock_lane),
        .rx_flag(rx_flag), .rx_ctrl(rx_ctrl), .rx_bad(rx_bad)
    );

    // ======================================================================
    // Scenarios
    // ======================================================================
    // Pass link edges; inputs change and outputs are read 1 ns after the edge.
    task automatic step(int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask

    // First blanking words after reset start from zero disparity, then alternate.
    task automatic blank_18();
        int i;
        i = 0;
        while (data_lane[0] === 7'h00 && i < 20) begin
            step(1);
            i++;
        end
        for (i = 0; i < 4; i++) begin
            `CHECK(data_lane[0], i[0] ? 7'h60 : 7'h7c, "hsync lane")
            `CHECK(data_lane[1], i[0] ? 7'h70 : 7'h78, "vsync lane")
            `CHECK(data_lane[5], i[0] ? 7'h60 : 7'h7c, "aux e lane")
            `CHECK(data_lane[4], i[0] ? 7'h70 : 7'h78, "aux f lane")
            `CHECK(primary_clock_lane, i[0] ? 7'h60 : 7'h7c, "clock lane")
            `CHECK(secondary_clock_lane, i[0] ? 7'h60 : 7'h7c, "second clock")
            `CHECK({data_lane[3], data_lane[7]}, 14'h0, "idle lanes")
            `CHECK({rx_bad, rx_flag, rx_ctrl}, 6'b001010, "decode")
            step(1);
        end
    endtask

    // Three heavy pixel words push the disparity past its limit before blanking.
    task automatic saturate(bdpe_word_t px, bdpe_word_t first, bdpe_word_t last);
        pixel_word = {8{px}};
        ctrl = 5'b11010;
        step(3);
        `CHECK(data_lane[0], px, "pixel pass")
        `CHECK({data_lane[3], data_lane[7]}, 14'h0, "idle lanes active")
        ctrl = 5'b01010;
        step(1);
        for (int k = 0; k < 5; k++) begin
            `CHECK(data_lane[0], (k < 4) ? first : last, "saturated choice")
            step(1);
        end
    endtask

    // With an active-low flag a high flag means blanking in 24-bit mode.
    task automatic polarity_24();
        cfg = 2'b10;
        ctrl = 5'b10101;
        step(6);
        `CHECK({rx_bad, rx_flag, rx_ctrl}, 6'b010101, "high flag blank")
        `CHECK({data_lane[3], data_lane[2]}, 14'h0, "unused lanes")
        ctrl = 5'b00010;
        pixel_word = {8{7'h2a}};
        step(2);
        `CHECK(data_lane, {8{7'h2a}}, "low flag pixels")
    endtask

    // ======================================================================
    // Verdict, watchdog and main sequence
    // ======================================================================
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The whole run needs about 38 link cycles; this cuts a hang well beyond.
    initial begin
        #20000;
        miscompares++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end

    // Reset must span three link edges as well, so it waits on both clocks.
    initial begin
        repeat (6) @(posedge sys_clk);
        repeat (3) @(posedge link_clk);
        #1;
        rst_b = 1'b1;
        blank_18();
        saturate(7'h7f, 7'h60, 7'h7c);
        saturate(7'h00, 7'h7c, 7'h60);
        polarity_24();
        results();
    end
endmodule
